/* hw/wdopt_top.v */
// Write-once option registers with the watchdog they configure, APB slave
//
// Functional notes
// - Each option register takes one write per reset; later writes ignored; always readable.
// - Any reset clears option bits; supply-range bit cleared only by power-on reset.
// - Supply-range bit write opens only after power-on reset.
// - Option registers decoded at indices 1E and 1F.
// - Oscillator keeps running in stop only when its option is set.
// - Serial clock source: bus clock when set, oscillator clock when clear.
// - Watchdog period 8176 cycles when set, 262128 when clear.
// - Monitor stays on in stop when stop-enable set and power-disable clear.
// - Reset-disable blocks monitor resets; power-disable turns monitor off.
// - Supply-range bit selects 5 V trip when set, 3 V when clear.
// - Stop exit waits 32 crystal cycles when short recovery set, else 4096.
// - Stop exit by external reset always uses the long recovery.
// - Stop instruction with stop disabled gives illegal-opcode reset; else stop entered.
// - Watchdog disable option set turns the watchdog off.
// - 6-bit counter after 12-bit prescaler on crystal clock; overflow resets.
// - Any service write clears counter and prescaler stages 12 to 5.
// - Reading the service location returns reset vector low byte.
// - Watchdog reset pulls reset pin low 32 crystal cycles, sets flag.
// - Stop removes crystal clock from watchdog and clears its prescaler.
// - Vector fetch clears prescaler; internal reset clears both; POR clears after 4096.
// - Monitor mode with test voltage disables watchdog; blank-vector entry until POR.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "wdopt_map.vh"

module wdopt_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire xclk_en,
  input wire sys_reset,
  input wire vector_fetch,
  input wire [7:0] reset_vector_lo,
  input wire stop_instr,
  input wire stop_wake,
  input wire stop_wake_by_reset,
  input wire wait_mode,
  input wire mon_mode,
  input wire mon_blank_entry,
  input wire tst_on_irq,
  input wire tst_on_rst,
  output reg osc_run_q,
  output reg serial_clock_source_sel_q,
  output reg monitor_enable_q,
  output reg monitor_reset_enable_q,
  output reg monitor_supply_range_q,
  output reg stop_mode_q,
  output reg stop_recovery_busy_q,
  output reg illegal_reset_q,
  output reg watchdog_reset_q,
  output reg rst_pin_o,
  output reg rst_pin_oe
);

  reg [7:0] opt_one_q;
  reg [7:0] opt_two_q;
  reg one_written_q;
  reg two_written_q;
  reg range_open_q;
  reg blank_dis_q;
  reg wd_flag_q;
  reg ill_flag_q;
  reg [12:0] rec_cnt_q;
  reg [12:0] por_cnt_q;
  reg por_done_q;
  reg por_clr_q;
  reg [5:0] rst_cnt_q;
  reg [7:0] rd_d;
  reg map_d;

  wire [15:0] idx;
  wire acc;
  wire wr;
  wire wr_ok;
  wire svc_wr;
  wire stop_go;
  wire stop_bad;
  wire stop_next;
  wire mon_dis;
  wire wd_active;
  wire wd_tick;
  wire wd_clr_all;
  wire wd_clr_pre;
  wire wd_overflow;
  wire rec_long;

  assign idx = paddr[17:2];
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign wr_ok = wr && !pslverr;

  // Address decode and read mux
  always @* begin
    map_d = 1'b1;
    rd_d = 8'h00;
    case (idx)
      `WDOPT_IDX_OPT_TWO: rd_d = opt_two_q;
      `WDOPT_IDX_OPT_ONE: rd_d = opt_one_q;
      `WDOPT_IDX_SERVICE: rd_d = reset_vector_lo;
      `WDOPT_IDX_TERMINATE: rd_d = 8'h00;
      `WDOPT_IDX_STATUS: begin
        rd_d = {stop_recovery_busy_q, stop_mode_q, blank_dis_q, range_open_q,
                two_written_q, one_written_q, ill_flag_q, wd_flag_q};
      end
      default: map_d = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      map_d = 1'b0;
    end
  end

  // APB answer: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable && !pready;
      if (psel && !penable && !pready) begin
        pslverr <= !map_d;
        prdata <= (map_d && !pwrite) ? {24'h000000, rd_d} : 32'h00000000;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  assign svc_wr = wr_ok && (idx == `WDOPT_IDX_SERVICE);

  // Option register one, write once, supply-range bit POR only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_one_q <= `WDOPT_OPT_RESET;
      one_written_q <= 1'b0;
      range_open_q <= 1'b1;
    end else if (sys_reset) begin
      opt_one_q <= opt_one_q & (8'h01 << `WDOPT_B1_SUPPLY_RANGE);
      one_written_q <= 1'b0;
    end else if (wr_ok && (idx == `WDOPT_IDX_OPT_ONE) && !one_written_q) begin
      opt_one_q <= range_open_q ? pwdata[7:0] :
        ((pwdata[7:0] & ~(8'h01 << `WDOPT_B1_SUPPLY_RANGE)) |
         (opt_one_q & (8'h01 << `WDOPT_B1_SUPPLY_RANGE)));
      one_written_q <= 1'b1;
      range_open_q <= 1'b0;
    end
  end

  // Option register two, write once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_two_q <= `WDOPT_OPT_RESET;
      two_written_q <= 1'b0;
    end else if (sys_reset) begin
      opt_two_q <= `WDOPT_OPT_RESET;
      two_written_q <= 1'b0;
    end else if (wr_ok && (idx == `WDOPT_IDX_OPT_TWO) && !two_written_q) begin
      opt_two_q <= pwdata[7:0] & `WDOPT_OPT_TWO_MASK;
      two_written_q <= 1'b1;
    end
  end

  // Stop entry and recovery
  assign stop_go = stop_instr && opt_one_q[`WDOPT_B1_STOP_ENABLE] && !stop_mode_q;
  assign stop_bad = stop_instr && !opt_one_q[`WDOPT_B1_STOP_ENABLE];
  assign rec_long = stop_wake_by_reset || !opt_one_q[`WDOPT_B1_SHORT_REC];
  // Stop state after this edge, so option-driven controls switch with it
  assign stop_next = stop_mode_q ? !(stop_wake || stop_wake_by_reset) : (stop_go && !sys_reset);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_mode_q <= 1'b0;
      stop_recovery_busy_q <= 1'b0;
      rec_cnt_q <= 13'h0000;
      illegal_reset_q <= 1'b0;
    end else begin
      illegal_reset_q <= stop_bad;
      if (sys_reset && !stop_mode_q) begin
        stop_recovery_busy_q <= 1'b0;
        rec_cnt_q <= 13'h0000;
      end else if (stop_mode_q && (stop_wake || stop_wake_by_reset)) begin
        stop_mode_q <= 1'b0;
        stop_recovery_busy_q <= 1'b1;
        rec_cnt_q <= rec_long ? `WDOPT_REC_LONG_CYC : `WDOPT_REC_SHORT_CYC;
      end else if (stop_go) begin
        stop_mode_q <= 1'b1;
      end else if (stop_recovery_busy_q && xclk_en) begin
        if (rec_cnt_q == 13'h0001) begin
          stop_recovery_busy_q <= 1'b0;
        end
        rec_cnt_q <= rec_cnt_q - 13'h0001;
      end
    end
  end

  // Power-on prescaler clear after 4096 crystal cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_q <= 13'h0000;
      por_done_q <= 1'b0;
      por_clr_q <= 1'b0;
    end else begin
      por_clr_q <= 1'b0;
      if (!por_done_q && xclk_en) begin
        if (por_cnt_q == (`WDOPT_POR_CLR_CYC - 13'h0001)) begin
          por_done_q <= 1'b1;
          por_clr_q <= 1'b1;
        end
        por_cnt_q <= por_cnt_q + 13'h0001;
      end
    end
  end

  // Blank-vector monitor entry holds the watchdog off until POR
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_dis_q <= 1'b0;
    end else if (mon_mode && mon_blank_entry && !tst_on_irq) begin
      blank_dis_q <= 1'b1;
    end
  end

  assign mon_dis = (mon_mode && (tst_on_irq || tst_on_rst)) || blank_dis_q;
  assign wd_active = !opt_one_q[`WDOPT_B1_WD_DISABLE] && !mon_dis;
  // Wait mode does not gate the tick
  assign wd_tick = xclk_en && wd_active && !stop_mode_q;
  assign wd_clr_all = sys_reset || !wd_active || watchdog_reset_q;
  assign wd_clr_pre = vector_fetch || por_clr_q || stop_go || stop_mode_q;

  wdopt_wdcount u_count (
    .pclk(pclk),
    .presetn(presetn),
    .tick(wd_tick),
    .period_sel(opt_one_q[`WDOPT_B1_WD_PERIOD]),
    .clr_all(wd_clr_all),
    .clr_pre(wd_clr_pre),
    .service(svc_wr),
    .overflow_q(wd_overflow)
  );

  // Reset pulse on the open-drain reset pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset_q <= 1'b0;
      rst_cnt_q <= 6'h00;
      rst_pin_o <= 1'b0;
      rst_pin_oe <= 1'b0;
    end else begin
      rst_pin_o <= 1'b0;
      watchdog_reset_q <= wd_overflow && !watchdog_reset_q;
      if (wd_overflow) begin
        rst_cnt_q <= `WDOPT_RST_PULSE_CYC;
        rst_pin_oe <= 1'b1;
      end else if (rst_pin_oe && xclk_en) begin
        if (rst_cnt_q == 6'h01) begin
          rst_pin_oe <= 1'b0;
        end
        rst_cnt_q <= rst_cnt_q - 6'h01;
      end
    end
  end

  // Sticky reset-cause flags; a new event wins over a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_flag_q <= 1'b0;
      ill_flag_q <= 1'b0;
    end else begin
      if (wd_overflow) begin
        wd_flag_q <= 1'b1;
      end else if (wr_ok && (idx == `WDOPT_IDX_STATUS) && pwdata[`WDOPT_BS_WD_FLAG]) begin
        wd_flag_q <= 1'b0;
      end
      if (stop_bad) begin
        ill_flag_q <= 1'b1;
      end else if (wr_ok && (idx == `WDOPT_IDX_STATUS) && pwdata[`WDOPT_BS_ILL_FLAG]) begin
        ill_flag_q <= 1'b0;
      end
    end
  end

  // Option-driven controls to clock, serial port and voltage monitor
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_q <= 1'b1;
      serial_clock_source_sel_q <= 1'b0;
      monitor_enable_q <= 1'b1;
      monitor_reset_enable_q <= 1'b1;
      monitor_supply_range_q <= 1'b0;
    end else begin
      osc_run_q <= !stop_next || opt_two_q[`WDOPT_B2_OSC_RUN];
      serial_clock_source_sel_q <= opt_two_q[`WDOPT_B2_SERIAL_SRC];
      monitor_enable_q <= !opt_one_q[`WDOPT_B1_MON_PWR_DIS] &&
        (!stop_next || opt_one_q[`WDOPT_B1_MON_STOP_EN]);
      monitor_reset_enable_q <= !opt_one_q[`WDOPT_B1_MON_PWR_DIS] &&
        !opt_one_q[`WDOPT_B1_MON_RST_DIS] &&
        (!stop_next || opt_one_q[`WDOPT_B1_MON_STOP_EN]);
      monitor_supply_range_q <= opt_one_q[`WDOPT_B1_SUPPLY_RANGE];
    end
  end

endmodule

/* hw/wdopt_map.vh */
// Register indices, option bit positions, reset values and crystal-cycle counts
`ifndef WDOPT_MAP_VH
`define WDOPT_MAP_VH

// Register indices; byte address is four times the index
`define WDOPT_IDX_OPT_TWO 16'h001e
`define WDOPT_IDX_OPT_ONE 16'h001f
`define WDOPT_IDX_SERVICE 16'hffff
`define WDOPT_IDX_TERMINATE 16'h0033
`define WDOPT_IDX_STATUS 16'h0040

// Option register two fields
`define WDOPT_B2_OSC_RUN 0
`define WDOPT_B2_SERIAL_SRC 1
`define WDOPT_OPT_TWO_MASK 8'h03

// Option register one fields
`define WDOPT_B1_WD_DISABLE 0
`define WDOPT_B1_STOP_ENABLE 1
`define WDOPT_B1_SHORT_REC 2
`define WDOPT_B1_SUPPLY_RANGE 3
`define WDOPT_B1_MON_PWR_DIS 4
`define WDOPT_B1_MON_RST_DIS 5
`define WDOPT_B1_MON_STOP_EN 6
`define WDOPT_B1_WD_PERIOD 7

// Status register fields
`define WDOPT_BS_WD_FLAG 0
`define WDOPT_BS_ILL_FLAG 1
`define WDOPT_BS_ONE_WRITTEN 2
`define WDOPT_BS_TWO_WRITTEN 3
`define WDOPT_BS_RANGE_OPEN 4
`define WDOPT_BS_BLANK_DIS 5
`define WDOPT_BS_STOP_MODE 6
`define WDOPT_BS_REC_BUSY 7

// Reset values
`define WDOPT_OPT_RESET 8'h00

// Timing counts in crystal-clock cycles
`define WDOPT_WD_LONG_CYC 18'd262128
`define WDOPT_WD_SHORT_CYC 18'd8176
`define WDOPT_RST_PULSE_CYC 6'd32
`define WDOPT_REC_SHORT_CYC 13'd32
`define WDOPT_REC_LONG_CYC 13'd4096
`define WDOPT_POR_CLR_CYC 13'd4096

`endif

/* hw/wdopt_wdcount.v */
// Watchdog prescaler and timeout counter
`timescale 1ns/1ps
`include "wdopt_map.vh"

module wdopt_wdcount (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire period_sel,
  input wire clr_all,
  input wire clr_pre,
  input wire service,
  output reg overflow_q
);

  reg [11:0] pre_q;
  reg [5:0] cnt_q;
  wire tap_wrap;
  wire [17:0] total;
  wire [17:0] limit;

  // Short period taps the prescaler at stage 7, long period at stage 12
  assign tap_wrap = period_sel ? (pre_q[6:0] == 7'h7f) : (pre_q == 12'hfff);
  assign total = period_sel ? {5'h00, cnt_q, pre_q[6:0]} : {cnt_q, pre_q};
  assign limit = period_sel ? (`WDOPT_WD_SHORT_CYC - 18'd1) : (`WDOPT_WD_LONG_CYC - 18'd1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 12'h000;
      cnt_q <= 6'h00;
      overflow_q <= 1'b0;
    end else if (clr_all) begin
      pre_q <= 12'h000;
      cnt_q <= 6'h00;
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= tick && !service && !clr_pre && (total == limit);
      if (clr_pre) begin
        pre_q <= 12'h000;
      end else if (service) begin
        pre_q <= {8'h00, pre_q[3:0]};
      end else if (tick) begin
        pre_q <= pre_q + 12'h001;
      end
      if (service) begin
        cnt_q <= 6'h00;
      end else if (tick && tap_wrap) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

endmodule

/* verification/wdopt_core_model.sv */
// Core-side model: crystal tick source and reset vector low byte
`timescale 1ns/1ps
module wdopt_core_model #(
  parameter logic [7:0] VEC_LO = 8'h5a
) (
  input logic pclk,
  input logic presetn,
  output logic xclk_en,
  output logic [7:0] reset_vector_lo
);
  // Crystal tick every cycle keeps the long counts short
  assign xclk_en = 1'b1;
  assign reset_vector_lo = VEC_LO;
endmodule

/* verification/wdopt_assertions.sv */
// Port-level checker for the option registers and watchdog
`timescale 1ns/1ps
module wdopt_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [17:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [7:0] reset_vector_lo,
  input logic stop_instr,
  input logic osc_run_q,
  input logic stop_mode_q,
  input logic illegal_reset_q,
  input logic watchdog_reset_q,
  input logic rst_pin_o,
  input logic rst_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_answer; psel && !penable |=> pready; endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");
  property p_ready_single; pready |=> !pready; endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held");
  property p_err_misalign; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && pready; endproperty
  a_err_misalign: assert property (p_err_misalign) else $error("misaligned accepted");
  property p_svc_read;
    pready && !pwrite && paddr == 18'h3fffc |-> prdata == {24'h000000, reset_vector_lo};
  endproperty
  a_svc_read: assert property (p_svc_read) else $error("service read wrong");
  property p_wd_pin; watchdog_reset_q |-> $rose(rst_pin_oe); endproperty
  a_wd_pin: assert property (p_wd_pin) else $error("pin not pulled");
  property p_pin_hold; watchdog_reset_q |=> rst_pin_oe [*8]; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin pulse short");
  property p_pin_low; rst_pin_oe |-> !rst_pin_o; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_illegal; illegal_reset_q |-> $past(stop_instr) && !stop_mode_q; endproperty
  a_illegal: assert property (p_illegal) else $error("spurious illegal reset");
  property p_stop_cause; $rose(stop_mode_q) |-> $past(stop_instr); endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop without cause");
  property p_osc_run; !stop_mode_q |-> osc_run_q; endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator off outside stop");
  c_wd: cover property (watchdog_reset_q);
  c_ill: cover property (illegal_reset_q);
  c_err: cover property (pslverr);
endmodule
bind wdopt_top wdopt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .reset_vector_lo(reset_vector_lo), .stop_instr(stop_instr),
  .osc_run_q(osc_run_q), .stop_mode_q(stop_mode_q), .illegal_reset_q(illegal_reset_q),
  .watchdog_reset_q(watchdog_reset_q), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));

/* verification/wdopt_bench.sv */
// Self-checking bench for the option registers and watchdog
`timescale 1ns/1ps
`include "wdopt_map.vh"
module wdopt_bench;
  localparam logic [17:0] a1 = {`WDOPT_IDX_OPT_ONE, 2'b00};
  localparam logic [17:0] a2 = {`WDOPT_IDX_OPT_TWO, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sys_reset = 0;
  logic stop_instr = 0, stop_wake = 0, stop_wake_by_reset = 0, wait_mode = 0;
  logic mon_mode = 0, mon_blank_entry = 0, tst_on_rst = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, got, xclk_en, osc_q, ser_q, mon_q, rst_q, rng_q;
  logic stop_q, busy_q, ill_q, wd_q, pin_o, pin_oe;
  logic [7:0] vec;
  int fails = 0, samples_checked = 0, n;
  wdopt_core_model core (.pclk(pclk), .presetn(presetn), .xclk_en(xclk_en),
    .reset_vector_lo(vec));
  wdopt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xclk_en(xclk_en), .sys_reset(sys_reset), .vector_fetch(1'b0),
    .reset_vector_lo(vec), .stop_instr(stop_instr), .stop_wake(stop_wake),
    .stop_wake_by_reset(stop_wake_by_reset), .wait_mode(wait_mode), .mon_mode(mon_mode),
    .mon_blank_entry(mon_blank_entry), .tst_on_irq(1'b0), .tst_on_rst(tst_on_rst),
    .osc_run_q(osc_q),
    .serial_clock_source_sel_q(ser_q), .monitor_enable_q(mon_q),
    .monitor_reset_enable_q(rst_q), .monitor_supply_range_q(rng_q), .stop_mode_q(stop_q),
    .stop_recovery_busy_q(busy_q), .illegal_reset_q(ill_q), .watchdog_reset_q(wd_q),
    .rst_pin_o(pin_o), .rst_pin_oe(pin_oe));
  initial forever #25 pclk = ~pclk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse_sys;
    @(posedge pclk);
    sys_reset <= 1;
    @(posedge pclk);
    sys_reset <= 0;
  endtask
  task t_opts;
    apb(1, {`WDOPT_IDX_TERMINATE, 2'b00}, 32'h1c);
    apb(0, a1, 0); chk(rd, 0);
    apb(0, a2, 0); chk(rd, 0);
    apb(1, a1, 32'h08); apb(1, a1, 32'h00); apb(0, a1, 0); chk(rd, 32'h08);
    apb(1, a2, 32'h03); apb(0, a2, 0); chk(rd, 32'h03);
    chk(ser_q, 1);
    chk(rng_q, 1);
    chk(mon_q, 1);
    chk(rst_q, 1);
    apb(0, 18'h00010, 0); chk(er, 1);
    apb(0, a1 + 18'h1, 0); chk(er, 1);
    apb(0, {`WDOPT_IDX_SERVICE, 2'b00}, 0); chk(rd, {24'h0, vec});
    $display("t_opts done");
  endtask
  task t_sysrst;
    pulse_sys;
    apb(0, a1, 0); chk(rd, 32'h08);
    apb(0, a2, 0); chk(rd, 0);
    apb(1, a1, 32'hb0); apb(0, a1, 0); chk(rd, 32'hb8);
    chk(mon_q, 0);
    chk(rst_q, 0);
    $display("t_sysrst done");
  endtask
  task t_wdog;
    wait_mode <= 1;
    repeat (3) begin
      apb(1, {`WDOPT_IDX_SERVICE, 2'b00}, 32'ha5);
      n = 0;
      repeat (4000) begin @(negedge pclk); n += wd_q; end
      chk(n, 0);
    end
    apb(1, {`WDOPT_IDX_SERVICE, 2'b00}, 32'h00);
    n = 0;
    do begin @(negedge pclk); n++; end while (!wd_q && n < 9000);
    chk((n > 8150) && (n < 8190), 1);
    n = 1;
    do begin @(negedge pclk); n += pin_oe; end while (pin_oe);
    chk(n, 32);
    apb(0, {`WDOPT_IDX_STATUS, 2'b00}, 0); chk(rd[0], 1);
    wait_mode <= 0;
    $display("t_wdog done");
  endtask
  task t_stop;
    pulse_sys;
    apb(1, a1, 32'h00);
    @(posedge pclk) stop_instr <= 1;
    @(posedge pclk) stop_instr <= 0;
    n = 0;
    repeat (3) begin @(negedge pclk); n += ill_q; end
    chk(n, 1);
    pulse_sys;
    apb(1, a1, 32'h06);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk) stop_instr <= 1;
      @(posedge pclk) stop_instr <= 0;
      repeat (2) @(negedge pclk);
      chk(stop_q, 1);
      chk(osc_q, 0);
      chk(mon_q, 0);
      chk(rst_q, 0);
      @(posedge pclk);
      stop_wake <= (k == 0);
      stop_wake_by_reset <= (k == 1);
      @(posedge pclk);
      stop_wake <= 0; stop_wake_by_reset <= 0;
      n = 0;
      repeat (4200) begin @(negedge pclk); n += busy_q; end
      chk((n >= (k ? 4096 : 32)) && (n <= (k ? 4098 : 34)), 1);
    end
    $display("t_stop done");
  endtask
  task t_mon;
    pulse_sys;
    apb(1, a1, 32'h80);
    mon_mode <= 1;
    tst_on_rst <= 1;
    n = 0;
    repeat (9000) begin @(negedge pclk); n += wd_q; end
    chk(n, 0);
    @(posedge pclk);
    tst_on_rst <= 0;
    mon_blank_entry <= 1;
    @(posedge pclk);
    mon_mode <= 0;
    mon_blank_entry <= 0;
    n = 0;
    repeat (9000) begin @(negedge pclk); n += wd_q; end
    chk(n, 0);
    apb(0, {`WDOPT_IDX_STATUS, 2'b00}, 0); chk(rd[5], 1);
    $display("t_mon done");
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    fails++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_opts;
    t_sysrst;
    t_wdog;
    t_stop;
    t_mon;
    finish_test;
  end
endmodule
